// File: rtl/dbc_bus_cycle.sv
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
// Notes on behaviour
// - Config bit picks synchronous or asynchronous handling of slave acknowledge.
// - Cleared bit: acknowledge goes through internal synchroniser, no alignment needed.
// - Asynchronous mode never finishes a memory cycle under three bus clocks.
// - Two user pin levels are latched into configuration word bits at reset release.
// - Latched user bits stay unchanged until the next hardware reset.
// - Two-bit field adds extra T2 states; 00 none, 01 one in synchronous mode and none in asynchronous mode.
module dbc_bus_cycle
	import dbc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DBC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [DBC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Bus pins toward the memory slave
	input wire logic slave_ready_in_i,
	input wire logic [1:0] size_acknowledge_in_i,
	input wire logic bus_style_select_i,
	input wire logic [1:0] user_pin_levels_i,
	output logic dma_strobe_o,
	output logic dma_t2_o,
	output logic dma_cycle_done_o
);
	typedef struct packed {
		// Bus slave
		logic [DBC_ADDR_W-1:0] aw_addr;
		logic aw_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic w_held;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// Configuration
		logic [DBC_CFG_WIDTH-1:0] cfg_other;
		logic sync_ack_select;
		logic [1:0] wait_state_count;
		// Cycle engine
		dbc_cycle_state_type state;
		logic cyc_sync;
		logic [1:0] wait_left;
		logic ack_prev;
		logic [7:0] cyc_len;
		logic [7:0] last_len;
		logic [15:0] cyc_count;
		logic done;
	} dbc_main_state_type;

	dbc_main_state_type cur;
	dbc_main_state_type next_cur;
	dbc_pin_if pins();
	logic ack_level;
	logic do_write;
	logic do_read;
	logic start_req;
	logic busy;
	logic [31:0] cfg_merged;

	// Saturating cycle-length counter
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	// Merges a write word into a stored word per byte strobe
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Assembles the configuration word as software sees it
	function automatic logic [31:0] config_word(input dbc_main_state_type s,
		input logic [1:0] user);
		logic [31:0] res;
		res = '0;
		res[DBC_CFG_SYNC_BIT] = s.sync_ack_select;
		res[DBC_CFG_USER_MSB:DBC_CFG_USER_LSB] = user;
		res[DBC_CFG_WAIT_MSB:DBC_CFG_WAIT_LSB] = s.wait_state_count;
		return res;
	endfunction

	// Pin synchroniser and reset-time user level capture
	dbc_pin_capture u_capture (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.slave_ready_in_i(slave_ready_in_i),
		.size_acknowledge_in_i(size_acknowledge_in_i),
		.bus_style_select_i(bus_style_select_i),
		.user_pin_levels_i(user_pin_levels_i),
		.pins(pins.capture)
	);

	// Bus style chooses which acknowledge pin ends the cycle
	assign ack_level = pins.style_level ? (|pins.size_ack_level)
		: pins.ready_level;

	// Handshake readies: one write and one read in flight at most
	assign s_axi_awready = !cur.aw_held && !cur.bvalid;
	assign s_axi_wready = !cur.w_held && !cur.bvalid;
	assign s_axi_arready = !cur.rvalid;
	assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign busy = (cur.state != DBC_IDLE);
	assign start_req = do_write && (cur.aw_addr == DBC_ADDR_CONTROL)
		&& cur.w_strb[0] && cur.w_data[DBC_CTRL_START_BIT];

	// Bus slave: address and data taken in either order, then answered
	always_comb begin
		next_cur = cur;
		// Config word with the pending write's byte lanes laid over it
		cfg_merged = merge_bytes(config_word(cur, pins.user_levels),
			cur.w_data, cur.w_strb);
		if (s_axi_awvalid && s_axi_awready) begin
			next_cur.aw_addr = s_axi_awaddr;
			next_cur.aw_held = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_cur.w_data = s_axi_wdata;
			next_cur.w_strb = s_axi_wstrb;
			next_cur.w_held = 1'b1;
		end
		if (cur.bvalid && s_axi_bready) begin
			next_cur.bvalid = 1'b0;
		end
		if (cur.rvalid && s_axi_rready) begin
			next_cur.rvalid = 1'b0;
		end

		// Register writes; a config change mid-cycle only affects the next
		if (do_write) begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = DBC_RESP_OKAY;
			unique case (cur.aw_addr)
				DBC_ADDR_CONFIG: begin
					next_cur.sync_ack_select =
						cfg_merged[DBC_CFG_SYNC_BIT];
					next_cur.wait_state_count =
						cfg_merged[DBC_CFG_WAIT_MSB:DBC_CFG_WAIT_LSB];
				end
				DBC_ADDR_CONTROL: begin
					// Start handled by the cycle engine below
				end
				DBC_ADDR_STATUS: begin
					// Status is read-only; writes are accepted and dropped
				end
				default: begin
					next_cur.bresp = DBC_RESP_SLVERR;
				end
			endcase
		end

		// Register reads come out of a flop one clock after the address
		if (do_read) begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = DBC_RESP_OKAY;
			next_cur.rdata = '0;
			unique case (s_axi_araddr)
				DBC_ADDR_CONFIG: begin
					next_cur.rdata = config_word(cur, pins.user_levels);
				end
				DBC_ADDR_CONTROL: begin
					next_cur.rdata = '0;
				end
				DBC_ADDR_STATUS: begin
					next_cur.rdata[DBC_STAT_BUSY_BIT] = busy;
					next_cur.rdata[DBC_STAT_MODE_BIT] = cur.cyc_sync;
					next_cur.rdata[DBC_STAT_USER_VALID_BIT] = pins.user_valid;
					next_cur.rdata[DBC_STAT_LEN_LSB +: 8] = cur.last_len;
					next_cur.rdata[DBC_STAT_CNT_LSB +: 16] = cur.cyc_count;
				end
				default: begin
					next_cur.rresp = DBC_RESP_SLVERR;
				end
			endcase
		end

		// Cycle engine: T1, then T2 repeated for waits and until acknowledge
		next_cur.done = 1'b0;
		next_cur.ack_prev = ack_level;
		unique case (cur.state)
			DBC_IDLE: begin
				if (start_req) begin
					next_cur.state = DBC_T1;
					next_cur.cyc_len = 8'h01;
					next_cur.cyc_sync = cur.sync_ack_select;
					next_cur.wait_left = cur.wait_state_count;
				end
			end
			DBC_T1: begin
				next_cur.state = DBC_T2;
				next_cur.cyc_len = sat_inc(cur.cyc_len);
			end
			DBC_T2: begin
				if (cur.wait_left != 2'h0) begin
					// Each code adds that many extra T2 states in synchronous mode; asynchronous mode adds one fewer for codes 01 to 11
					next_cur.wait_left = cur.wait_left - 2'h1;
					next_cur.cyc_len = sat_inc(cur.cyc_len);
				end else if (cur.cyc_sync) begin
					// One synchroniser output sample at this edge ends the cycle; no second sample
					if (ack_level && cur.cyc_len >= DBC_MIN_SYNC_CLKS) begin
						next_cur.state = DBC_DONE;
					end else begin
						next_cur.cyc_len = sat_inc(cur.cyc_len);
					end
				end else begin
					// Two agreeing samples filter a level caught mid-change
					if (ack_level && cur.ack_prev
						&& cur.cyc_len >= DBC_MIN_ASYNC_CLKS) begin
						next_cur.state = DBC_DONE;
					end else begin
						next_cur.cyc_len = sat_inc(cur.cyc_len);
					end
				end
			end
			DBC_DONE: begin
				next_cur.state = DBC_IDLE;
				next_cur.done = 1'b1;
				next_cur.last_len = cur.cyc_len;
				next_cur.cyc_count = cur.cyc_count + 16'h0001;
			end
		endcase
	end

	// All state in one register; synchronous active-low reset
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cur <= '0;
			cur.state <= DBC_IDLE;
			cur.sync_ack_select <= DBC_SYNC_RESET;
			cur.wait_state_count <= DBC_WAIT_RESET;
			cur.bresp <= DBC_RESP_OKAY;
			cur.rresp <= DBC_RESP_OKAY;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs straight from state flops
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rdata = cur.rdata;
	assign s_axi_rresp = cur.rresp;
	assign dma_strobe_o = (cur.state == DBC_T1) || (cur.state == DBC_T2);
	assign dma_t2_o = (cur.state == DBC_T2);
	assign dma_cycle_done_o = cur.done;
endmodule
`default_nettype wire

// File: rtl/dbc_pkg.sv
`default_nettype none
package dbc_pkg;
	// Register byte addresses on the control bus
	localparam int DBC_ADDR_W = 4;
	localparam logic [DBC_ADDR_W-1:0] DBC_ADDR_CONFIG = 4'h0;
	localparam logic [DBC_ADDR_W-1:0] DBC_ADDR_CONTROL = 4'h4;
	localparam logic [DBC_ADDR_W-1:0] DBC_ADDR_STATUS = 4'h8;

	// Field positions of dma_data_configuration
	localparam int DBC_CFG_WIDTH = 16;
	localparam int DBC_CFG_WAIT_LSB = 6;
	localparam int DBC_CFG_WAIT_MSB = 7;
	localparam int DBC_CFG_USER_LSB = 8;
	localparam int DBC_CFG_USER_MSB = 9;
	localparam int DBC_CFG_SYNC_BIT = 10;
	localparam logic [1:0] DBC_WAIT_RESET = 2'h0;
	localparam logic DBC_SYNC_RESET = 1'b0;

	// Field positions of the control and status words
	localparam int DBC_CTRL_START_BIT = 0;
	localparam int DBC_STAT_BUSY_BIT = 0;
	localparam int DBC_STAT_MODE_BIT = 1;
	localparam int DBC_STAT_USER_VALID_BIT = 2;
	localparam int DBC_STAT_LEN_LSB = 8;
	localparam int DBC_STAT_CNT_LSB = 16;

	// Cycle timing in bus clocks
	localparam logic [7:0] DBC_MIN_ASYNC_CLKS = 8'h03;
	localparam logic [7:0] DBC_MIN_SYNC_CLKS = 8'h02;
	localparam int DBC_SYNC_STAGES = 2;

	// AXI responses
	localparam logic [1:0] DBC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DBC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DBC_IDLE,
		DBC_T1,
		DBC_T2,
		DBC_DONE
	} dbc_cycle_state_type;
endpackage
`default_nettype wire

// File: rtl/dbc_pin_if.sv
`default_nettype none
interface dbc_pin_if;
	// Synchronised pin levels and the captured user levels
	logic ready_level;
	logic [1:0] size_ack_level;
	logic style_level;
	logic [1:0] user_levels;
	logic user_valid;

	modport capture (
		output ready_level,
		output size_ack_level,
		output style_level,
		output user_levels,
		output user_valid
	);
	modport engine (
		input ready_level,
		input size_ack_level,
		input style_level,
		input user_levels,
		input user_valid
	);
endinterface
`default_nettype wire

// File: rtl/dbc_pin_capture.sv
`default_nettype none
module dbc_pin_capture
	import dbc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Raw pins
	input wire logic slave_ready_in_i,
	input wire logic [1:0] size_acknowledge_in_i,
	input wire logic bus_style_select_i,
	input wire logic [1:0] user_pin_levels_i,
	// Toward the cycle engine
	dbc_pin_if.capture pins
);
	localparam int W = 6;

	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
		logic [1:0] settle;
		logic [1:0] user;
		logic valid;
	} dbc_cap_state_type;

	dbc_cap_state_type cur;
	dbc_cap_state_type next_cur;

	// Two flops on every pin; after release the chain needs two edges
	// before it holds real pin levels, hence the settle counter
	always_comb begin
		next_cur = cur;
		next_cur.stage1 = {user_pin_levels_i, bus_style_select_i,
			size_acknowledge_in_i, slave_ready_in_i};
		next_cur.stage2 = cur.stage1;
		if (!cur.valid) begin
			if (cur.settle == 2'(DBC_SYNC_STAGES)) begin
				next_cur.user = cur.stage2[5:4];
				next_cur.valid = 1'b1;
			end else begin
				next_cur.settle = cur.settle + 2'h1;
			end
		end
	end

	// Captured levels only change through reset
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Pin levels from the second stage; user levels and valid from the capture flops
	assign pins.ready_level = cur.stage2[0];
	assign pins.size_ack_level = cur.stage2[2:1];
	assign pins.style_level = cur.stage2[3];
	assign pins.user_levels = cur.user;
	assign pins.user_valid = cur.valid;
endmodule
`default_nettype wire

// File: tb/dbc_ack_model.sv
`default_nettype none
module dbc_ack_model (
	// Clock and cycle from the engine; bus style and delay from the bench
	input wire logic core_clk_i,
	input wire logic dma_strobe_o,
	input wire logic bus_style_select_i,
	input wire logic [3:0] delay_i,
	// Acknowledge pins
	output logic ack_ready_o = 1'h0,
	output logic [1:0] ack_size_o = 2'h0
);
	logic [3:0] cnt = 4'h0;
	logic ack;
	// Zero delay stands for a no-wait memory that ties its ready active
	assign ack = (delay_i == 4'h0) || (dma_strobe_o && cnt >= delay_i);
	// Pins move just after the edge, so they are stable around it
	always @(posedge core_clk_i) begin
		cnt <= dma_strobe_o ? cnt + 4'h1 : 4'h0;
		ack_ready_o <= !bus_style_select_i && ack;
		ack_size_o <= {bus_style_select_i && ack, 1'h0};
	end
endmodule
`default_nettype wire

// File: tb/dbc_bus_cycle_sva.sv
`default_nettype none
module dbc_bus_cycle_sva
	import dbc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [DBC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DBC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// Bus pins
	input wire logic slave_ready_in_i,
	input wire logic [1:0] size_acknowledge_in_i,
	input wire logic bus_style_select_i,
	input wire logic [1:0] user_pin_levels_i,
	input wire logic dma_strobe_o,
	input wire logic dma_t2_o,
	input wire logic dma_cycle_done_o
);
	logic sync_q, rd_cfg;
	logic [1:0] wait_q, usr_q;
	logic [2:0] age;
	logic [7:0] t2n;
	wire logic ack = bus_style_select_i ? |size_acknowledge_in_i
		: slave_ready_in_i;
	// Shadow of the config, assuming address and data come together
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sync_q <= 1'h0;
			wait_q <= 2'h0;
			usr_q <= user_pin_levels_i;
			age <= 3'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
				&& s_axi_awaddr == DBC_ADDR_CONFIG) begin
				sync_q <= s_axi_wdata[DBC_CFG_SYNC_BIT];
				wait_q <= s_axi_wdata[DBC_CFG_WAIT_MSB:DBC_CFG_WAIT_LSB];
			end
			if (age != 3'h7)
				age <= age + 3'h1;
		end
		if (s_axi_arvalid && s_axi_arready)
			rd_cfg <= s_axi_araddr == DBC_ADDR_CONFIG;
		t2n <= dma_t2_o ? t2n + 8'h1 : 8'h0;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	ack_sync_a: assert property (
		(sync_q && wait_q == 2'h0 && dma_t2_o && ack)[*3] |=> !dma_t2_o)
		else $error("sync cycle ran on");
	ack_async_a: assert property (
		(!sync_q && wait_q == 2'h0 && dma_t2_o && ack)[*4] |=> !dma_t2_o)
		else $error("async cycle ran on");
	ack_hold_a: assert property (
		(dma_t2_o && !ack)[*3] |=> dma_t2_o)
		else $error("cycle ended without ack");
	min_len_a: assert property (
		$rose(dma_strobe_o) && !sync_q |-> dma_strobe_o[*3])
		else $error("async cycle too short");
	user_lvl_a: assert property (
		s_axi_rvalid && rd_cfg && age == 3'h7
		|-> s_axi_rdata[DBC_CFG_USER_MSB:DBC_CFG_USER_LSB] == usr_q)
		else $error("user levels wrong");
	wait_low_a: assert property (
		$fell(dma_t2_o) && !wait_q[1] |-> t2n > {6'h0, wait_q})
		else $error("too few wait states");
	wait_high_a: assert property (
		$fell(dma_t2_o) && wait_q[1] |-> t2n > {6'h0, wait_q})
		else $error("too few long wait states");
	done_pulse_a: assert property (
		$fell(dma_strobe_o) |=> dma_cycle_done_o ##1 !dma_cycle_done_o)
		else $error("done pulse wrong");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top
	import dbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'h0, rst_n_i = 1'h0, bus_style_select_i = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, delay = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] user_pin_levels_i = 2'h2, s_axi_bresp, s_axi_rresp;
	logic [1:0] size_acknowledge_in_i;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, slave_ready_in_i, dma_strobe_o, dma_t2_o;
	logic dma_cycle_done_o;
	int errors = 0, checked = 0, ncyc = 0;
	dbc_bus_cycle dut_u (.*);
	dbc_ack_model ack_u (.core_clk_i, .dma_strobe_o, .bus_style_select_i,
		.delay_i(delay), .ack_ready_o(slave_ready_in_i),
		.ack_size_o(size_acknowledge_in_i));
	// Clock of 50 ns
	always #25 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Handshakes are judged at the falling edge, acted on at the rising
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic at, wt, bt;
		@(posedge core_clk_i);
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge core_clk_i);
			at = s_axi_awvalid && s_axi_awready;
			wt = s_axi_wvalid && s_axi_wready;
			bt = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk_i);
			if (at)
				s_axi_awvalid <= 1'h0;
			if (wt)
				s_axi_wvalid <= 1'h0;
		end while (!bt);
		s_axi_bready <= 1'h0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic at, rt;
		@(posedge core_clk_i);
		s_axi_arvalid <= 1'h1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge core_clk_i);
			at = s_axi_arvalid && s_axi_arready;
			rt = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk_i);
			if (at)
				s_axi_arvalid <= 1'h0;
		end while (!rt);
		s_axi_rready <= 1'h0;
	endtask
	// One DMA cycle, waiting on busy; the wait is cut by the watchdog
	task automatic cyc(output logic [31:0] st);
		logic [1:0] r;
		axw(DBC_ADDR_CONTROL, 32'h1, r);
		ncyc++;
		do axr(DBC_ADDR_STATUS, st, r); while (st[DBC_STAT_BUSY_BIT]);
		chk({16'h0, st[31:16]}, 32'(ncyc));
	endtask
	task automatic t_reset;
		logic [31:0] st;
		logic [1:0] r;
		axr(DBC_ADDR_CONFIG, st, r);
		chk(st, 32'h200);
		axr(DBC_ADDR_STATUS, st, r);
		chk(st, 32'h4);
		axr(4'hC, st, r);
		chk({30'h0, r}, {30'h0, DBC_RESP_SLVERR});
		chk(st, 32'h0);
		axw(4'hC, 32'hFFFF, r);
		chk({30'h0, r}, {30'h0, DBC_RESP_SLVERR});
	endtask
	// Every mode and wait code against a memory that answers at once
	task automatic t_modes;
		logic [31:0] st, e;
		logic [1:0] r;
		for (int s = 0; s < 2; s++) begin
			for (int w = 0; w < 4; w++) begin
				e = (32'(s) << DBC_CFG_SYNC_BIT) | (32'(w) << DBC_CFG_WAIT_LSB);
				axw(DBC_ADDR_CONFIG, e, r);
				axr(DBC_ADDR_CONFIG, st, r);
				chk(st, e | 32'h200);
				cyc(st);
				chk({31'h0, st[DBC_STAT_MODE_BIT]}, 32'(s));
				chk({24'h0, st[15:8]}, (s == 0 && w == 0) ? 32'h3
					: 32'(w) + 32'h2);
			end
		end
	endtask
	// Slow memory on both acknowledge pins and in both modes
	task automatic t_slow;
		logic [31:0] st;
		logic [1:0] r;
		for (int i = 0; i < 4; i++) begin
			bus_style_select_i <= 1'(i);
			delay <= 4'h5;
			axw(DBC_ADDR_CONFIG, 32'(i >> 1) << DBC_CFG_SYNC_BIT, r);
			cyc(st);
			chk({31'h0, st[15:8] > 8'h5}, 32'h1);
		end
		delay <= 4'h0;
	endtask
	// Pins change and software writes the field; the levels must not move
	task automatic t_user;
		logic [31:0] st;
		logic [1:0] r;
		user_pin_levels_i <= 2'h1;
		axw(DBC_ADDR_CONFIG, 32'h100, r);
		axr(DBC_ADDR_CONFIG, st, r);
		chk(st, 32'h200);
	endtask
	task automatic stop_test;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		repeat (5) @(posedge core_clk_i);
		t_reset;
		t_modes;
		t_slow;
		t_user;
		stop_test;
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge core_clk_i);
		errors++;
		stop_test;
	end
endmodule
bind dbc_bus_cycle dbc_bus_cycle_sva sva_u (.*);
`default_nettype wire
